// ---- srhl_ref_select.sv ----
// Purpose: reference selection, holdover flags and VCXO lock window check
// Assumes: loss and validation pulses come from same-clock monitor logic
// Notes: ref, feedback and VCXO pins are resynchronised before use
`timescale 1ns/1ps
`default_nettype none
module srhl_ref_select (
  input wire logic clock_in, // 200 MHz clock
  input wire logic reset_n_in, // sync reset
  input wire logic ref_clk_in, // selected input pin
  input wire logic fb_clk_in, // feedback pin
  input wire logic vcxo_clk_in, // VCXO output pin
  input wire logic [srhl_pkg::NUM_IN-1:0] loss_of_signal_event_in, // loss
  input wire logic [srhl_pkg::NUM_IN-1:0] validated_in, // revalidated
  input wire logic [srhl_pkg::NUM_IN-1:0] input_sticky_clear_in, // W1C
  input wire logic reference_sticky_clear_in, // W1C
  input wire logic lock_sticky_clear_in, // W1C
  input wire logic [1:0] selection_mode_code_in, // mode
  input wire logic [srhl_pkg::SEL_W-1:0] manual_select_in, // designated
  input wire logic [srhl_pkg::NUM_IN*srhl_pkg::PRIO_W-1:0] priority_in,
  input wire logic revertive_enable_in, // revertive
  input wire logic [srhl_pkg::PSEL_W-1:0] holdoff_prescaler_select_in,
  input wire logic [srhl_pkg::HOLD_W-1:0] holdoff_start_value_in,
  input wire logic [srhl_pkg::WCODE_W-1:0] window_start_code_in, // before
  input wire logic [srhl_pkg::WCODE_W-1:0] window_end_code_in, // after
  output logic [srhl_pkg::SEL_W-1:0] active_input_indicator_out, // active
  output logic reference_valid_status_out, // high when valid
  output logic reference_loss_sticky_out, // low after loss
  output logic holdover_active_out, // holdover
  output logic [srhl_pkg::NUM_IN-1:0] input_valid_status_out, // per input
  output logic [srhl_pkg::NUM_IN-1:0] input_loss_sticky_out, // per input
  output logic [srhl_pkg::HOLD_W-1:0] holdoff_count_out, // countdown
  output logic vcxo_lock_lost_status_out, // momentary
  output logic vcxo_lock_lost_sticky_out // sticky
);
  import srhl_pkg::*;

  // Highest priority member of the mask; ties go to lower index
  function automatic logic [SEL_W:0] best_valid(
      input logic [NUM_IN-1:0] m,
      input logic [NUM_IN*PRIO_W-1:0] p);
    logic [SEL_W:0] r;
    logic [PRIO_W-1:0] bp;
    r = '0;
    bp = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (m[i] && (!r[SEL_W] || p[i*PRIO_W +: PRIO_W] > bp)) begin
        r = {1'b1, SEL_W'(i)};
        bp = p[i*PRIO_W +: PRIO_W];
      end
    end
    return r;
  endfunction

  function automatic logic [THR_W-1:0] win_cycles(
      input logic [WCODE_W-1:0] c,
      input logic [PER_W-1:0] per_long,
      input logic [PER_W-1:0] per_ref);
    logic [PER_W-1:0] per;
    logic [THR_W-1:0] prod;
    per = (c < WCODE_LONG) ? per_ref : per_long;
    prod = THR_W'(half_span(c)) * THR_W'(per);
    return prod >> 1;
  endfunction

  // Pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] ref_sync_reg;
  logic [2:0] fb_sync_reg;
  logic [2:0] vcxo_sync_reg;
  logic ref_edge;
  logic fb_edge;
  logic vcxo_edge;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ref_sync_reg <= 3'h0;
      fb_sync_reg <= 3'h0;
      vcxo_sync_reg <= 3'h0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_in};
      fb_sync_reg <= {fb_sync_reg[1:0], fb_clk_in};
      vcxo_sync_reg <= {vcxo_sync_reg[1:0], vcxo_clk_in};
    end
  end

  assign ref_edge = ref_sync_reg[1] && !ref_sync_reg[2];
  assign fb_edge = fb_sync_reg[1] && !fb_sync_reg[2];
  // Pins faster than half the clock alias; the VCXO is expected divided
  assign vcxo_edge = vcxo_sync_reg[1] && !vcxo_sync_reg[2];

  // Per-input status and sticky flags
  logic [NUM_IN-1:0] in_valid_reg;
  logic [NUM_IN-1:0] in_sticky_reg;
  logic [NUM_IN-1:0] los_acc;

  assign los_acc = loss_of_signal_event_in & in_sticky_reg;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      in_valid_reg <= VALID_RST;
      in_sticky_reg <= STICKY_RST;
    end else begin
      in_valid_reg <= (in_valid_reg & ~los_acc) | validated_in;
      // Loss wins over a clear in the same cycle
      in_sticky_reg <= (in_sticky_reg |
        (input_sticky_clear_in & in_valid_reg)) & ~los_acc;
    end
  end

  // Selection state
  srhl_sel_t state_reg;
  logic [SEL_W-1:0] act_reg;
  logic ref_ok_reg;
  logic ref_sticky_reg;
  logic revert_reg;
  logic sel_los;
  logic expire;
  logic [SEL_W:0] best_other;
  logic [SEL_W:0] best_all;
  logic higher;
  logic [NUM_IN-1:0] act_mask;

  assign act_mask = NUM_IN'(1) << act_reg;
  assign sel_los = |(los_acc & act_mask);
  assign best_other = best_valid(in_valid_reg & ~act_mask, priority_in);
  assign best_all = best_valid(in_valid_reg, priority_in);
  assign higher = best_all[SEL_W] &&
    priority_in[best_all[SEL_W-1:0]*PRIO_W +: PRIO_W] >
    priority_in[act_reg*PRIO_W +: PRIO_W];

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      revert_reg <= REVERT_RST;
    end else begin
      revert_reg <= revertive_enable_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_reg <= SRHL_TRACK;
      act_reg <= SEL_RST;
      ref_ok_reg <= 1'b0;
      ref_sticky_reg <= 1'b1;
    end else begin
      // Refused while the reference is not valid; a loss below overrides
      if (reference_sticky_clear_in && ref_ok_reg) begin
        ref_sticky_reg <= 1'b1;
      end
      case (state_reg)
        SRHL_TRACK: begin
          case (selection_mode_code_in)
            MODE_AUTO: begin
              if (sel_los) begin
                if (best_other[SEL_W]) begin
                  act_reg <= best_other[SEL_W-1:0];
                end else begin
                  ref_ok_reg <= 1'b0;
                  ref_sticky_reg <= 1'b0;
                end
              end else if (!ref_ok_reg && best_all[SEL_W]) begin
                act_reg <= best_all[SEL_W-1:0];
                ref_ok_reg <= 1'b1;
              end else if (revert_reg && higher) begin
                act_reg <= best_all[SEL_W-1:0];
              end
            end
            MODE_AUTOHOLD: begin
              if (sel_los) begin
                state_reg <= SRHL_COUNT;
                ref_ok_reg <= 1'b0;
                ref_sticky_reg <= 1'b0;
              end else if (revert_reg && higher && ref_ok_reg) begin
                act_reg <= best_all[SEL_W-1:0];
              end else if (validated_in[act_reg]) begin
                ref_ok_reg <= 1'b1;
              end
            end
            default: begin
              if (sel_los) begin
                ref_ok_reg <= 1'b0;
                ref_sticky_reg <= 1'b0;
                if (selection_mode_code_in == MODE_SHORT) begin
                  state_reg <= SRHL_SHORT_HOLD;
                end
              end else begin
                // Indicator frozen on the loss cycle itself
                act_reg <= manual_select_in;
                if (validated_in[act_reg]) begin
                  ref_ok_reg <= 1'b1;
                end
              end
            end
          endcase
        end
        SRHL_SHORT_HOLD: begin
          if (selection_mode_code_in != MODE_SHORT) begin
            state_reg <= SRHL_TRACK;
          end else if (validated_in[act_reg]) begin
            state_reg <= SRHL_TRACK;
            ref_ok_reg <= 1'b1;
          end
        end
        SRHL_COUNT: begin
          // Validations here touch only per-input flags
          if (selection_mode_code_in != MODE_AUTOHOLD) begin
            state_reg <= SRHL_TRACK;
          end else if (expire) begin
            if (in_valid_reg[act_reg]) begin
              state_reg <= SRHL_TRACK;
              ref_ok_reg <= 1'b1;
            end else if (best_other[SEL_W]) begin
              state_reg <= SRHL_TRACK;
              act_reg <= best_other[SEL_W-1:0];
              ref_ok_reg <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= SRHL_TRACK;
        end
      endcase
    end
  end

  // Countdown runs only while the lost reference waits in auto-holdover
  srhl_holdoff u_holdoff (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .run_in(state_reg == SRHL_COUNT &&
      selection_mode_code_in == MODE_AUTOHOLD),
    .step_in(vcxo_edge),
    .presc_sel_in(holdoff_prescaler_select_in),
    .start_value_in(holdoff_start_value_in),
    .expire_out(expire),
    .count_out(holdoff_count_out)
  );

  // Lock window: cycles since each edge and latched periods
  logic [PER_W-1:0] ref_cnt_reg;
  logic [PER_W-1:0] fb_cnt_reg;
  logic [PER_W-1:0] ref_per_reg;
  logic [PER_W-1:0] fb_per_reg;
  logic [THR_W-1:0] start_thr;
  logic [THR_W-1:0] end_thr;
  logic pend_reg;
  logic lost_reg;
  logic lost_sticky_reg;
  logic lock_fail;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ref_cnt_reg <= PER_MAX;
      ref_per_reg <= PER_MAX;
    end else if (ref_edge) begin
      ref_cnt_reg <= '0;
      ref_per_reg <= ref_cnt_reg;
    end else if (ref_cnt_reg != PER_MAX) begin
      ref_cnt_reg <= ref_cnt_reg + PER_W'(1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      fb_cnt_reg <= PER_MAX;
      fb_per_reg <= PER_MAX;
    end else if (fb_edge) begin
      fb_cnt_reg <= '0;
      fb_per_reg <= fb_cnt_reg;
    end else if (fb_cnt_reg != PER_MAX) begin
      fb_cnt_reg <= fb_cnt_reg + PER_W'(1);
    end
  end

  assign start_thr = win_cycles(window_start_code_in, ref_per_reg,
    ref_per_reg);
  assign end_thr = win_cycles(window_end_code_in, fb_per_reg,
    ref_per_reg);
  assign lock_fail = pend_reg && !fb_edge && !ref_edge &&
    THR_W'(ref_cnt_reg) > end_thr;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      pend_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else if (ref_edge) begin
      // A late feedback from the previous edge counts as a miss
      if (pend_reg) begin
        lost_reg <= 1'b1;
      end
      if (fb_edge || THR_W'(fb_cnt_reg) <= start_thr) begin
        lost_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else begin
        pend_reg <= 1'b1;
      end
    end else if (pend_reg && fb_edge) begin
      pend_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else if (lock_fail) begin
      pend_reg <= 1'b0;
      lost_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      lost_sticky_reg <= 1'b0;
    end else if (lock_fail || (ref_edge && pend_reg)) begin
      lost_sticky_reg <= 1'b1;
    end else if (lock_sticky_clear_in) begin
      lost_sticky_reg <= 1'b0;
    end
  end

  assign active_input_indicator_out = act_reg;
  assign reference_valid_status_out = ref_ok_reg;
  assign reference_loss_sticky_out = ref_sticky_reg;
  assign holdover_active_out = state_reg != SRHL_TRACK;
  assign input_valid_status_out = in_valid_reg;
  assign input_loss_sticky_out = in_sticky_reg;
  assign vcxo_lock_lost_status_out = lost_reg;
  assign vcxo_lock_lost_sticky_out = lost_sticky_reg;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  property p_armed;
    los_acc == '0 && validated_in == '0 |=> $stable(in_valid_reg);
  endproperty
  a_armed: assert property (p_armed) else $error("disarmed loss acted");

  property p_clr;
    (input_sticky_clear_in & ~in_valid_reg & ~in_sticky_reg) != '0 |=>
      (in_sticky_reg & $past(input_sticky_clear_in & ~in_valid_reg &
      ~in_sticky_reg)) == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("sticky cleared unvalidated");

  property p_short;
    state_reg == SRHL_TRACK && selection_mode_code_in == MODE_SHORT &&
      sel_los |=> holdover_active_out && !ref_ok_reg && !ref_sticky_reg
      && act_reg == $past(act_reg);
  endproperty
  a_short: assert property (p_short) else $error("short holdover entry");

  property p_enter;
    state_reg == SRHL_TRACK && selection_mode_code_in == MODE_AUTOHOLD &&
      sel_los |=> state_reg == SRHL_COUNT && !ref_ok_reg && !ref_sticky_reg;
  endproperty
  a_enter: assert property (p_enter) else $error("countdown not started");

  property p_freeze;
    state_reg == SRHL_COUNT && selection_mode_code_in == MODE_AUTOHOLD &&
      !expire |=> $stable(act_reg) && !ref_ok_reg;
  endproperty
  a_freeze: assert property (p_freeze) else $error("selection moved");

  property p_none;
    state_reg == SRHL_COUNT && selection_mode_code_in == MODE_AUTOHOLD &&
      expire && in_valid_reg == '0 |=> state_reg == SRHL_COUNT &&
      !ref_ok_reg && !ref_sticky_reg;
  endproperty
  a_none: assert property (p_none) else $error("left holdover, none valid");

  property p_fail;
    lock_fail |=> lost_reg && lost_sticky_reg;
  endproperty
  a_fail: assert property (p_fail) else $error("loss of lock missed");

  property p_inwin;
    ref_edge && fb_edge |=> !lost_reg && !pend_reg;
  endproperty
  a_inwin: assert property (p_inwin) else $error("lock not declared");

  c_switch: cover property (state_reg == SRHL_COUNT && expire &&
    best_other[SEL_W] && !in_valid_reg[act_reg]);
  c_short: cover property (state_reg == SRHL_SHORT_HOLD ##1
    state_reg == SRHL_TRACK);
  c_lost: cover property (lock_fail);
endmodule // srhl_ref_select
`default_nettype wire

// ---- srhl_pkg.sv ----
// Purpose: shared constants for reference select, holdover and lock detect
// Assumes: one 200 MHz clock, period 5 ns; control bits arrive as ports
// Notes: input and reference loss flags are active low, a written 1 restores them; lock-lost flags are active high
// Notes on behaviour
// - Hold-off counter is an 8-bit down-counter; reaching zero triggers reselection.
// - Hold-off counter steps on VCXO edges divided by the selected prescaler.
// - On every expiry the counter reloads the programmed start value.
// - Prescaler and counter run only in auto-holdover mode with selected input lost.
// - An input raises no new loss until its sticky loss flag is cleared.
// - Revertive switch in auto modes only to an input of higher priority.
// - Revertive disabled means no switch on revalidation; disabled after reset.
// - Short holdover: loss on designated input enters holdover, flags low, indicator kept.
// - Short holdover: revalidated designated input leaves holdover, reference status high.
// - Sticky loss flags clear on a written 1, only once validated.
// - Auto-holdover: loss on active input enters holdover, flags low, countdown starts.
// - During countdown every input keeps reporting its own loss events.
// - Validation during countdown sets input status only; selection and revertive ignored.
// - Expiry with active input revalidated keeps it and leaves holdover.
// - Expiry with active input lost switches to next valid priority input.
// - Expiry with nothing valid stays in holdover; reference sticky refuses clearing.
// - After countdown, revertive switching resumes when enabled.
// - Lock detector reports loss of lock by momentary and sticky bits.
// - Lock holds only if feedback edge falls inside window around reference edge.
// - Window codes 2 to 7 span two to the k minus one periods.
// - Window code 0 gives half, code 1 one and a half reference periods.
// - Auto mode: loss fails over at once; no valid input means no switch.
// - Priorities 0 to 3; changes in auto modes may switch at once.
package srhl_pkg;
  localparam int NUM_IN = 4;
  localparam int SEL_W = 2;
  localparam int PRIO_W = 2;
  localparam int HOLD_W = 8;
  localparam int PSEL_W = 5;
  localparam int PRE_W = 32;
  localparam int PER_W = 16;
  localparam int WCODE_W = 3;
  localparam int HALF_W = 8;
  localparam int THR_W = PER_W + HALF_W;
  localparam real CLK_PERIOD_NS = 5.0;
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_SHORT = 2'h2;
  localparam logic [1:0] MODE_AUTOHOLD = 2'h3;
  localparam logic REVERT_RST = 1'b0;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
  localparam logic [NUM_IN-1:0] VALID_RST = 4'h0;
  localparam logic [NUM_IN-1:0] STICKY_RST = 4'hF;
  localparam logic [HOLD_W-1:0] HOLD_RST = 8'h00;
  localparam logic [PER_W-1:0] PER_MAX = 16'hFFFF;
  localparam logic [WCODE_W-1:0] WCODE_LONG = 3'h2;
  localparam logic [HALF_W-1:0] HALF_CODE0 = 8'h01;
  localparam logic [HALF_W-1:0] HALF_CODE1 = 8'h03;

  typedef enum logic [1:0] {SRHL_TRACK, SRHL_SHORT_HOLD, SRHL_COUNT} srhl_sel_t;

  // Window edge in half periods
  function automatic logic [HALF_W-1:0] half_span(
      input logic [WCODE_W-1:0] code);
    logic [HALF_W-1:0] r;
    r = HALF_CODE0;
    if (code == 3'h1) begin
      r = HALF_CODE1;
    end else if (code >= WCODE_LONG) begin
      r = HALF_W'(((1 << code) - 1) * 2);
    end
    return r;
  endfunction
endpackage

// ---- srhl_holdoff.sv ----
// Purpose: hold-off prescaler and 8-bit down-counter
// Assumes: step_in is a one-cycle pulse per VCXO rising edge
// Notes: prescale ratio is two to the power of the select value
`timescale 1ns/1ps
`default_nettype none
module srhl_holdoff (
  input wire logic clock_in, // system clock
  input wire logic reset_n_in, // sync reset
  input wire logic run_in, // countdown allowed
  input wire logic step_in, // VCXO edge pulse
  input wire logic [srhl_pkg::PSEL_W-1:0] presc_sel_in, // ratio select
  input wire logic [srhl_pkg::HOLD_W-1:0] start_value_in, // start value
  output logic expire_out, // expiry pulse
  output logic [srhl_pkg::HOLD_W-1:0] count_out // current count
);
  import srhl_pkg::*;
  logic [PRE_W-1:0] pre_reg;
  logic [HOLD_W-1:0] cnt_reg;
  logic expire_reg;
  logic tick;
  logic [PRE_W-1:0] limit;

  assign limit = (PRE_W'(1) << presc_sel_in) - PRE_W'(1);
  assign tick = run_in && step_in && (pre_reg >= limit);

  // Held at zero when idle, while the count loads the start value
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || !run_in) begin
      pre_reg <= '0;
    end else if (step_in) begin
      pre_reg <= tick ? '0 : pre_reg + PRE_W'(1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cnt_reg <= HOLD_RST;
    end else if (!run_in) begin
      cnt_reg <= start_value_in;
    end else if (tick) begin
      if (cnt_reg <= HOLD_W'(1)) begin
        cnt_reg <= start_value_in;
      end else begin
        cnt_reg <= cnt_reg - HOLD_W'(1);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= tick && (cnt_reg <= HOLD_W'(1));
    end
  end

  assign expire_out = expire_reg;
  assign count_out = cnt_reg;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  property p_reload;
    tick && cnt_reg <= HOLD_W'(1) |=>
      expire_reg && cnt_reg == $past(start_value_in);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at expiry");

  // Second cycle may expire only if the count ran again in between
  property p_idle;
    !run_in |=> pre_reg == '0 && !expire_reg ##1
      (!expire_reg || $past(run_in));
  endproperty
  a_idle: assert property (p_idle) else $error("counter ran while idle");

  property p_step;
    run_in && !tick |=> $stable(cnt_reg);
  endproperty
  a_step: assert property (p_step) else $error("count moved without tick");

  c_expire: cover property (expire_reg);
endmodule // srhl_holdoff
`default_nettype wire

// ---- srhl_clk_model.sv ----
// Purpose: far-side clock sources for the reference selector
// Assumes: reference and feedback share one period
// Notes: feedback stops low when disabled, as a dead divider would
`timescale 1ns/1ps
`default_nettype none
module srhl_clk_model #(
  parameter real REF_NS = 80.0,
  parameter real VCXO_NS = 20.0
) (
  input wire logic fb_enable_in, // feedback runs
  output logic ref_clk_out, // selected input
  output logic fb_clk_out, // feedback
  output var logic vcxo_clk_out // VCXO
);
  logic ref_q;
  // Odd offset keeps pin edges away from the system clock edges
  initial begin
    ref_q = 1'b0;
    #1.3;
    forever #(REF_NS / 2.0) ref_q = ~ref_q;
  end
  initial begin
    vcxo_clk_out = 1'b0;
    #0.7;
    forever #(VCXO_NS / 2.0) vcxo_clk_out = ~vcxo_clk_out;
  end
  assign ref_clk_out = ref_q;
  // In phase while locked, so any window code must hold lock
  assign fb_clk_out = ref_q & fb_enable_in;
endmodule // srhl_clk_model
`default_nettype wire

// ---- tb_srhl_ref_select.sv ----
// Purpose: self-checking bench for reference select and lock detect
// Assumes: pulses last one cycle, flags settle within two cycles
// Notes: prescaler 8 and start 3 keep each countdown near 100 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_srhl_ref_select;
  import srhl_pkg::*;
  localparam int LIMIT = 20000;
  logic clk, rst_n, rclr, lclr, rev, fb_en, ref_clk, fb_clk, vcxo_clk;
  logic rstat, rstk, hold, llost, lstk;
  logic [3:0] loss, val, iclr, istat, istk;
  logic [1:0] mode, msel, ind;
  logic [7:0] prio, hstart, cnt;
  logic [4:0] psel;
  logic [2:0] wst, wen;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  srhl_clk_model model (.fb_enable_in(fb_en), .ref_clk_out(ref_clk),
    .fb_clk_out(fb_clk), .vcxo_clk_out(vcxo_clk));
  srhl_ref_select dut (.clock_in(clk), .reset_n_in(rst_n),
    .ref_clk_in(ref_clk), .fb_clk_in(fb_clk), .vcxo_clk_in(vcxo_clk),
    .loss_of_signal_event_in(loss), .validated_in(val),
    .input_sticky_clear_in(iclr), .reference_sticky_clear_in(rclr),
    .lock_sticky_clear_in(lclr), .selection_mode_code_in(mode),
    .manual_select_in(msel), .priority_in(prio),
    .revertive_enable_in(rev), .holdoff_prescaler_select_in(psel),
    .holdoff_start_value_in(hstart), .window_start_code_in(wst),
    .window_end_code_in(wen), .active_input_indicator_out(ind),
    .reference_valid_status_out(rstat), .reference_loss_sticky_out(rstk),
    .holdover_active_out(hold), .input_valid_status_out(istat),
    .input_loss_sticky_out(istk), .holdoff_count_out(cnt),
    .vcxo_lock_lost_status_out(llost), .vcxo_lock_lost_sticky_out(lstk));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  task check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle pulse: 0 loss, 1 valid, 2 input clear, 3 ref clear, 4 lock
  task pulse(input int k, input logic [3:0] v);
    @(negedge clk);
    case (k)
      0: loss = v;
      1: val = v;
      2: iclr = v;
      3: rclr = v[0];
      default: lclr = v[0];
    endcase
    @(negedge clk);
    {loss, val, iclr, rclr, lclr} = '0;
    cyc(2);
  endtask

  task wait_hold(input logic v);
    int i;
    for (i = 0; i < 400 && hold !== v; i++) begin
      @(negedge clk);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    {loss, val, iclr, rclr, lclr} = '0;
    mode = MODE_SHORT;
    msel = 2'h0;
    prio = 8'h27;
    rev = 1'b0;
    psel = 5'h03;
    hstart = 8'h03;
    wst = 3'h2;
    wen = 3'h0;
    fb_en = 1'b1;
    cyc(2);
    check("count", cnt, 8'h00);
    check("input sticky", istk, 8'h0F);
    check("lock sticky", lstk, 8'h00);
    rst_n = 1'b1;
    pulse(1, 4'hF);
    check("input status", istat, 8'h0F);
    pulse(0, 4'h1);
    check("holdover", hold, 8'h01);
    check("ref status", rstat, 8'h00);
    check("ref sticky", rstk, 8'h00);
    cyc(120);
    check("indicator", ind, 8'h00);
    check("count", cnt, 8'h03);
    pulse(1, 4'h1);
    check("holdover", hold, 8'h00);
    check("ref status", rstat, 8'h01);
    pulse(3, 4'h1);
    pulse(2, 4'h1);
    check("ref sticky", rstk, 8'h01);
    check("input sticky", istk, 8'h0F);
    mode = MODE_AUTOHOLD;
    cyc(4);
    check("indicator", ind, 8'h00);
    pulse(0, 4'h1);
    check("holdover", hold, 8'h01);
    check("ref sticky", rstk, 8'h00);
    check("count", cnt, 8'h03);
    pulse(0, 4'h4);
    check("input status", istat, 8'h0A);
    check("input sticky", istk, 8'h0A);
    pulse(2, 4'h4);
    check("input sticky", istk, 8'h0A);
    pulse(1, 4'h4);
    check("input status", istat, 8'h0E);
    check("ref status", rstat, 8'h00);
    check("indicator", ind, 8'h00);
    cyc(30);
    check("holdover", hold, 8'h01);
    wait_hold(1'b0);
    check("indicator", ind, 8'h02);
    check("ref status", rstat, 8'h01);
    cyc(40);
    check("count", cnt, 8'h03);
    pulse(1, 4'h1);
    check("indicator", ind, 8'h02);
    pulse(2, 4'h5);
    pulse(0, 4'h1);
    rev = 1'b1;
    pulse(1, 4'h8);
    check("indicator", ind, 8'h02);
    pulse(1, 4'h1);
    check("indicator", ind, 8'h00);
    pulse(2, 4'hF);
    pulse(0, 4'hE);
    pulse(0, 4'h1);
    cyc(300);
    check("holdover", hold, 8'h01);
    check("indicator", ind, 8'h00);
    pulse(3, 4'h1);
    check("ref sticky", rstk, 8'h00);
    pulse(1, 4'h1);
    wait_hold(1'b0);
    check("indicator", ind, 8'h00);
    check("ref status", rstat, 8'h01);
    pulse(3, 4'h1);
    check("ref sticky", rstk, 8'h01);
    pulse(1, 4'h4);
    pulse(2, 4'hF);
    mode = MODE_AUTO;
    pulse(0, 4'h1);
    check("indicator", ind, 8'h02);
    check("holdover", hold, 8'h00);
    // Every window code, feedback in phase
    for (int k = 0; k < 8; k++) begin
      wst = 3'(k);
      wen = 3'(k);
      cyc(100);
      check("lock lost", llost, 8'h00);
    end
    // Widest window still tolerates a short feedback gap
    fb_en = 1'b0;
    cyc(100);
    check("lock lost", llost, 8'h00);
    wst = 3'h2;
    wen = 3'h0;
    cyc(100);
    check("lock lost", llost, 8'h01);
    check("lock sticky", lstk, 8'h01);
    fb_en = 1'b1;
    cyc(60);
    check("lock lost", llost, 8'h00);
    check("lock sticky", lstk, 8'h01);
    pulse(4, 4'h1);
    check("lock sticky", lstk, 8'h00);
    give_verdict();
  end
endmodule // tb_srhl_ref_select
`default_nettype wire
